/* src/hbus_decoder_consts.vh */
// Constants for the host bus request decoder
`ifndef HBUS_DECODER_CONSTS_VH
`define HBUS_DECODER_CONSTS_VH

// ----------------------------------------
// First request phase codes
// ----------------------------------------
`define CODE_DEFER_REPLY 5'h00
`define CODE_RESERVED_01 5'h01
`define CODE_MEM_RD_INV 5'h02
`define CODE_RESERVED_03 5'h03
`define CODE_MEM_CODE_RD 5'h04
`define CODE_MEM_WB 5'h05
`define CODE_MEM_DATA_RD 5'h06
`define CODE_MEM_WR 5'h07
`define CODE_INTA_SPEC 5'h08
`define CODE_BTM 5'h09
`define CODE_IO_RD 5'h10
`define CODE_IO_WR 5'h11

// ----------------------------------------
// Second phase codes and field positions
// ----------------------------------------
`define CODE2_INTA 5'h00
`define CODE2_SPECIAL 5'h01
`define CODE2_BTM 5'h00
`define SIZE_MSB 4
`define SIZE_LSB 3
`define SIZE_OK 2'h0
`define LEN_MSB 1
`define LEN_LSB 0
`define LEN_UPTO8 2'h0
`define LEN_16 2'h1
`define LEN_32 2'h2
`define LEN_RSVD 2'h3

// ----------------------------------------
// Routing targets
// ----------------------------------------
`define ROUTE_NONE 3'h0
`define ROUTE_DRAM 3'h1
`define ROUTE_HUB 3'h2
`define ROUTE_LOCAL 3'h3
`define ROUTE_SPECIAL 3'h4
`define ROUTE_DEFER 3'h5
`define ROUTE_DISCARD 3'h6

// ----------------------------------------
// Response status encodings
// ----------------------------------------
`define RESP_IDLE 3'h0
`define RESP_RETRY 3'h1
`define RESP_DEFER 3'h2
`define RESP_NODATA 3'h5
`define RESP_IWB 3'h6
`define RESP_DATA 3'h7

// ----------------------------------------
// Queue depth
// ----------------------------------------
`define IOQ_DEPTH 4
`define IOQ_PTR_W 2

`endif

/* src/hbus_req_classify.v */
// Combinational classification of one decoded host bus request
`timescale 1ns/1ps
`include "hbus_decoder_consts.vh"

module hbus_req_classify (
   // Request phase codes
   input wire [4:0] i_code_one,
   input wire [4:0] i_code_two,
   // Address side information
   input wire i_addr_dram,
   input wire i_addr_cfg,
   // Classification result
   output reg [2:0] o_route,
   output reg o_is_write,
   output reg o_is_mem,
   output reg o_bad_len
);

   wire [1:0] len_code;
   wire size_ok;

   // Field extraction; both size codes checked for memory cycles, phase two only for I/O
   assign len_code = i_code_two[`LEN_MSB:`LEN_LSB];
   assign size_ok = (i_code_one[`SIZE_MSB:`SIZE_LSB] == `SIZE_OK) &&
                    (i_code_two[`SIZE_MSB:`SIZE_LSB] == `SIZE_OK);

   // ----------------------------------------
   // Decode table
   // ----------------------------------------
   always @* begin
      o_route = `ROUTE_NONE;
      o_is_write = 1'b0;
      o_is_mem = 1'b0;
      o_bad_len = (len_code == `LEN_RSVD);
      case (i_code_one)
         `CODE_DEFER_REPLY: begin
            o_route = `ROUTE_DEFER;
            o_bad_len = 1'b0;
         end
         `CODE_INTA_SPEC: begin
            o_bad_len = 1'b0;
            if (i_code_two == `CODE2_INTA)
               o_route = `ROUTE_HUB;
            else if (i_code_two == `CODE2_SPECIAL)
               o_route = `ROUTE_SPECIAL;
         end
         `CODE_BTM: begin
            o_bad_len = 1'b0;
            if (i_code_two == `CODE2_BTM) begin
               o_route = `ROUTE_DISCARD;
               o_is_write = 1'b1;
            end
         end
         `CODE_IO_RD, `CODE_IO_WR: begin
            o_is_write = i_code_one[0];
            // Own config space stays local
            if (i_code_two[`SIZE_MSB:`SIZE_LSB] == `SIZE_OK && !o_bad_len)
               o_route = i_addr_cfg ? `ROUTE_LOCAL : `ROUTE_HUB;
         end
         `CODE_MEM_RD_INV, `CODE_MEM_CODE_RD, `CODE_MEM_DATA_RD: begin
            o_is_mem = 1'b1;
            if (size_ok && !o_bad_len)
               o_route = i_addr_dram ? `ROUTE_DRAM : `ROUTE_HUB;
         end
         `CODE_MEM_WB: begin
            o_is_mem = 1'b1;
            o_is_write = 1'b1;
            if (size_ok && !o_bad_len)
               o_route = `ROUTE_DRAM;
         end
         `CODE_MEM_WR: begin
            o_is_mem = 1'b1;
            o_is_write = 1'b1;
            if (size_ok && !o_bad_len)
               o_route = i_addr_dram ? `ROUTE_DRAM : `ROUTE_HUB;
         end
         default: begin
            o_route = `ROUTE_NONE;
         end
      endcase
   end

endmodule

/* src/hbus_request_decoder.v */
// Host bus request decoder with in-order queue and response selection
`timescale 1ns/1ps
`include "hbus_decoder_consts.vh"

module hbus_request_decoder #(
   parameter DEPTH = `IOQ_DEPTH,
   parameter PTR_W = `IOQ_PTR_W
) (
   // Clock, reset, enable
   input wire i_ref_clk,
   input wire i_sys_rst,
   input wire i_clk_en,
   // Request phase from processor bus logic
   input wire i_req_valid,
   input wire [4:0] i_request_code_phase_one,
   input wire [4:0] i_request_code_phase_two,
   input wire [7:0] i_byte_lane_enables,
   input wire i_addr_dram,
   input wire i_addr_cfg,
   input wire i_locked,
   // Snoop result of the oldest transaction not yet snooped
   input wire i_snoop_valid,
   input wire i_snoop_hitm,
   // Downstream resource state
   input wire i_dram_busy,
   input wire i_hub_busy,
   input wire i_defer_enable,
   // Response strobe from bus logic
   input wire i_resp_ready,
   // Queue status and dispatch
   output reg o_ioq_full,
   output reg o_dispatch_valid,
   output reg [2:0] o_dispatch_route,
   output reg o_dispatch_write,
   output reg [7:0] o_byte_lane_enables,
   // Response status lines
   output reg o_resp_valid,
   output reg o_response_status_bit_two,
   output reg o_response_status_bit_one,
   output reg o_response_status_bit_zero
);

   // ----------------------------------------
   // Queue storage and pointers
   // ----------------------------------------
   reg [2:0] q_route [0:DEPTH-1];
   reg q_write [0:DEPTH-1];
   reg q_empty_rd [0:DEPTH-1];
   reg q_locked [0:DEPTH-1];
   reg q_hitm [0:DEPTH-1];
   reg q_snooped [0:DEPTH-1];
   reg q_mem [0:DEPTH-1];
   reg [PTR_W-1:0] wr_ptr;
   reg [PTR_W-1:0] rd_ptr;
   reg [PTR_W-1:0] snp_ptr;
   reg [PTR_W:0] count;
   reg [PTR_W:0] snp_count;

   wire [2:0] cls_route;
   wire cls_write;
   wire cls_mem;
   wire cls_bad_len;
   wire push;
   wire pop;
   wire snoop_take;
   reg [2:0] next_status;
   reg [2:0] head_route;
   reg head_write;

   // Pointer advance with wrap, used by all three pointers
   function [PTR_W-1:0] ptr_inc;
      input [PTR_W-1:0] p;
      begin
         if (p == DEPTH[PTR_W-1:0] - 1'b1)
            ptr_inc = {PTR_W{1'b0}};
         else
            ptr_inc = p + 1'b1;
      end
   endfunction

   // ----------------------------------------
   // Request classification
   // ----------------------------------------
   hbus_req_classify u_classify (
      .i_code_one(i_request_code_phase_one),
      .i_code_two(i_request_code_phase_two),
      .i_addr_dram(i_addr_dram),
      .i_addr_cfg(i_addr_cfg),
      .o_route(cls_route),
      .o_is_write(cls_write),
      .o_is_mem(cls_mem),
      .o_bad_len(cls_bad_len)
   );

   // Full queue refuses new requests; bus logic must stall the pipeline
   assign push = i_clk_en && i_req_valid && (count < DEPTH);
   // Response only after the head has its snoop result
   assign pop = i_clk_en && i_resp_ready && (count != 0) && (snp_count != 0);
   assign snoop_take = i_clk_en && i_snoop_valid && (count > snp_count);

   // ----------------------------------------
   // Head of queue view
   // ----------------------------------------
   always @* begin
      head_route = q_route[rd_ptr];
      head_write = q_write[rd_ptr];
   end

   // ----------------------------------------
   // Response status selection
   // ----------------------------------------
   // Retry and defer only for classes that permit them; writeback never
   always @* begin
      next_status = `RESP_NODATA;
      if (q_hitm[rd_ptr]) begin
         next_status = `RESP_IWB;
      end else begin
         case (head_route)
            `ROUTE_HUB: begin
               if (i_hub_busy)
                  next_status = `RESP_RETRY;
               else if (i_defer_enable && (!head_write || !cls_mem_dummy(1'b0)))
                  next_status = `RESP_DEFER;
               else
                  next_status = head_write ? `RESP_NODATA : `RESP_DATA;
            end
            `ROUTE_DRAM: begin
               if (i_dram_busy && q_locked[rd_ptr] && !head_write)
                  next_status = `RESP_RETRY;
               else if (head_write || q_empty_rd[rd_ptr])
                  next_status = `RESP_NODATA;
               else
                  next_status = `RESP_DATA;
            end
            `ROUTE_LOCAL: begin
               if (head_write || q_empty_rd[rd_ptr])
                  next_status = `RESP_NODATA;
               else
                  next_status = `RESP_DATA;
            end
            default: begin
               // Deferred reply, special, discard and rejected requests
               next_status = `RESP_NODATA;
            end
         endcase
      end
   end

   // Hub memory writes are not deferrable; I/O writes are
   function cls_mem_dummy;
      input dummy;
      begin
         cls_mem_dummy = dummy | q_mem[rd_ptr];
      end
   endfunction

   // ----------------------------------------
   // Queue and pointer update
   // ----------------------------------------
   integer k;
   always @(posedge i_ref_clk or posedge i_sys_rst) begin
      if (i_sys_rst) begin
         wr_ptr <= {PTR_W{1'b0}};
         rd_ptr <= {PTR_W{1'b0}};
         snp_ptr <= {PTR_W{1'b0}};
         count <= {(PTR_W+1){1'b0}};
         snp_count <= {(PTR_W+1){1'b0}};
         for (k = 0; k < DEPTH; k = k + 1) begin
            q_route[k] <= `ROUTE_NONE;
            q_write[k] <= 1'b0;
            q_empty_rd[k] <= 1'b0;
            q_locked[k] <= 1'b0;
            q_hitm[k] <= 1'b0;
            q_snooped[k] <= 1'b0;
            q_mem[k] <= 1'b0;
         end
      end else if (i_clk_en) begin
         if (push) begin
            q_route[wr_ptr] <= cls_bad_len ? `ROUTE_NONE : cls_route;
            q_write[wr_ptr] <= cls_write;
            q_mem[wr_ptr] <= cls_mem;
            q_empty_rd[wr_ptr] <= (i_byte_lane_enables == 8'h00) && !cls_write;
            q_locked[wr_ptr] <= i_locked;
            q_hitm[wr_ptr] <= 1'b0;
            q_snooped[wr_ptr] <= 1'b0;
            wr_ptr <= ptr_inc(wr_ptr);
         end
         // Snoop results arrive in request order
         if (snoop_take) begin
            q_hitm[snp_ptr] <= i_snoop_hitm;
            q_snooped[snp_ptr] <= 1'b1;
            snp_ptr <= ptr_inc(snp_ptr);
         end
         if (pop)
            rd_ptr <= ptr_inc(rd_ptr);
         count <= count + {{PTR_W{1'b0}}, push} - {{PTR_W{1'b0}}, pop};
         snp_count <= snp_count + {{PTR_W{1'b0}}, snoop_take} - {{PTR_W{1'b0}}, pop};
      end
   end

   // ----------------------------------------
   // Registered outputs
   // ----------------------------------------
   always @(posedge i_ref_clk or posedge i_sys_rst) begin
      if (i_sys_rst) begin
         o_ioq_full <= 1'b0;
         o_dispatch_valid <= 1'b0;
         o_dispatch_route <= `ROUTE_NONE;
         o_dispatch_write <= 1'b0;
         o_byte_lane_enables <= 8'h00;
         o_resp_valid <= 1'b0;
         o_response_status_bit_two <= 1'b0;
         o_response_status_bit_one <= 1'b0;
         o_response_status_bit_zero <= 1'b0;
      end else if (i_clk_en) begin
         o_ioq_full <= (count + {{PTR_W{1'b0}}, push} - {{PTR_W{1'b0}}, pop}) == DEPTH;
         o_dispatch_valid <= push;
         o_dispatch_route <= cls_bad_len ? `ROUTE_NONE : cls_route;
         o_dispatch_write <= cls_write;
         // Trace messages carry no data downstream
         o_byte_lane_enables <= (cls_route == `ROUTE_DISCARD) ? 8'h00 :
                                i_byte_lane_enables;
         o_resp_valid <= pop;
         // Idle encoding between responses
         if (pop) begin
            o_response_status_bit_two <= next_status[2];
            o_response_status_bit_one <= next_status[1];
            o_response_status_bit_zero <= next_status[0];
         end else begin
            o_response_status_bit_two <= 1'b0;
            o_response_status_bit_one <= 1'b0;
            o_response_status_bit_zero <= 1'b0;
         end
      end
   end

endmodule

/* test/hbus_decoder_checker.sv */
// Assertion checker for the host bus request decoder
`timescale 1ns/1ps
module hbus_decoder_checker #(parameter DEPTH = 4, parameter PTR_W = 2) (
   // Clock, reset and request side
   input wire i_ref_clk, i_sys_rst, i_clk_en, i_req_valid, i_addr_cfg, i_resp_ready,
   input wire [4:0] i_request_code_phase_one, i_request_code_phase_two,
   // Queue, dispatch and response side
   input wire o_ioq_full, o_dispatch_valid, o_resp_valid,
   input wire [2:0] o_dispatch_route,
   input wire [7:0] o_byte_lane_enables,
   input wire o_response_status_bit_two, o_response_status_bit_one, o_response_status_bit_zero
);
   // ----------------------------------------
   // Request classes seen at the pins
   // ----------------------------------------
   wire [4:0] c1 = i_request_code_phase_one;
   wire [4:0] c2 = i_request_code_phase_two;
   wire [2:0] st = {o_response_status_bit_two, o_response_status_bit_one,
      o_response_status_bit_zero};
   wire take = i_clk_en & i_req_valid & ~o_ioq_full;
   // Size and length legal, otherwise the request is rejected outright
   wire ok = c2[4:3] == 2'h0 && c2[1:0] != 2'h3;
   wire wb = c1 == 5'h05 && ok;
   wire cfg_io = (c1 == 5'h10 || c1 == 5'h11) && i_addr_cfg && ok;
   wire rsv = c1 == 5'h01 || (c1 != 5'h00 && c2[1:0] == 2'h3);
   wire btm = c1 == 5'h09 && c2 == 5'h00;

   default clocking @(posedge i_ref_clk); endclocking
   default disable iff (i_sys_rst);

   a_take_dispatch: assert property (take |=> o_dispatch_valid)
      else $error("accepted request not dispatched");
   a_dispatch_cause: assert property (o_dispatch_valid |-> $past(take))
      else $error("dispatch without accepted request");
   a_full_drops: assert property (i_req_valid && o_ioq_full ##1 1 |-> !o_dispatch_valid)
      else $error("request taken while queue full");
   a_status_idle: assert property (!o_resp_valid |-> st == 3'h0)
      else $error("status not idle outside response");
   a_no_bad_status: assert property (st != 3'h4 && st != 3'h3)
      else $error("hard failure or reserved status driven");
   a_resp_cause: assert property (o_resp_valid |-> $past(i_resp_ready))
      else $error("response without response strobe");
   a_wb_dram: assert property (o_dispatch_valid && $past(wb) |-> o_dispatch_route == 3'h1)
      else $error("writeback not sent to memory");
   a_cfg_local: assert property ($past(cfg_io) && o_dispatch_valid |-> o_dispatch_route == 3'h3)
      else $error("config space I/O left the block");
   a_rsvd_kept: assert property (o_dispatch_valid && $past(rsv)
      |-> o_dispatch_route != 3'h1 && o_dispatch_route != 3'h2)
      else $error("reserved request routed downstream");
   a_trace_blank: assert property (o_dispatch_valid && $past(btm) |-> o_byte_lane_enables == 0)
      else $error("trace message data kept");

   c_full: cover property (o_ioq_full);
   c_retry: cover property (st == 3'h1);
   c_defer: cover property (st == 3'h2);
endmodule

bind hbus_request_decoder hbus_decoder_checker #(.DEPTH(DEPTH), .PTR_W(PTR_W)) u_chk (.*);

/* test/hbus_host_model.sv */
// Host processor model issuing requests, snoop results and response strobes
`timescale 1ns/1ps
module hbus_host_model (
   // Bus clock
   input wire i_ref_clk,
   // Request phase
   output logic o_req, o_dram, o_cfg, o_lock,
   output logic [4:0] o_c1, o_c2,
   output logic [7:0] o_be,
   // Snoop and response strobes
   output logic o_snp, o_hitm, o_rdy
);
   logic [20:0] rq[$];
   logic sq[$];
   logic phase = 0;

   initial {o_req, o_dram, o_cfg, o_lock, o_c1, o_c2, o_be, o_snp, o_hitm, o_rdy} = 0;

   // ----------------------------------------
   // One request a cycle, then snoop and strobe
   // ----------------------------------------
   // Idle lines are inverted each cycle so a stale value never looks valid
   always @(negedge i_ref_clk) begin
      o_req = rq.size() != 0;
      if (o_req) {o_lock, o_cfg, o_dram, o_c1, o_c2, o_be} = rq.pop_front();
      else {o_lock, o_cfg, o_dram, o_c1, o_c2, o_be} = ~{o_lock, o_cfg, o_dram, o_c1, o_c2, o_be};
      o_rdy = phase;
      o_snp = !phase && sq.size() != 0;
      o_hitm = o_snp ? sq.pop_front() : ~o_hitm;
      phase = o_snp;
   end
endmodule

/* test/hbus_request_decoder_test.sv */
// Self-checking testbench for the host bus request decoder
`timescale 1ns/1ps
`define CHK(g, e) begin num_checks++; if ((g) !== (e)) begin err_total++; \
   $display("BAD t=%0t got %h exp %h", $time, g, e); end end
module hbus_request_decoder_test;
   logic i_ref_clk = 0, i_sys_rst = 1, i_clk_en = 1;
   logic i_dram_busy = 0, i_hub_busy = 0, i_defer_enable = 0;
   wire i_req_valid, i_addr_dram, i_addr_cfg, i_locked, i_snoop_valid, i_snoop_hitm, i_resp_ready;
   wire [4:0] i_request_code_phase_one, i_request_code_phase_two;
   wire [7:0] i_byte_lane_enables, o_byte_lane_enables;
   wire o_ioq_full, o_dispatch_valid, o_dispatch_write, o_resp_valid;
   wire o_response_status_bit_two, o_response_status_bit_one, o_response_status_bit_zero;
   wire [2:0] o_dispatch_route;
   wire [2:0] st = {o_response_status_bit_two, o_response_status_bit_one,
      o_response_status_bit_zero};
   int err_total = 0;
   int num_checks = 0;

   hbus_request_decoder dut (.*);
   hbus_host_model host (.i_ref_clk(i_ref_clk), .o_req(i_req_valid), .o_dram(i_addr_dram),
      .o_cfg(i_addr_cfg), .o_lock(i_locked), .o_c1(i_request_code_phase_one),
      .o_c2(i_request_code_phase_two), .o_be(i_byte_lane_enables), .o_snp(i_snoop_valid),
      .o_hitm(i_snoop_hitm), .o_rdy(i_resp_ready));

   // 20 MHz bus clock
   always #25 i_ref_clk = ~i_ref_clk;

   // ----------------------------------------
   // Shared helpers
   // ----------------------------------------
   task report_and_stop;
      $display("Checks %0d mismatches %0d", num_checks, err_total);
      if (err_total == 0 && num_checks > 0) $display("Testbench passed");
      else $display("Testbench failed");
      $finish;
   endtask

   task req(input [4:0] c1, c2, input [7:0] be, input d, c, l);
      host.rq.push_back({l, c, d, c1, c2, be});
   endtask

   // Bounded wait on the dispatch pulse, then judge route and lanes
   task wait_disp(input [2:0] rt, input [7:0] be, input wr);
      int i;
      i = 0;
      do begin @(negedge i_ref_clk); i++; end while (o_dispatch_valid !== 1'b1 && i < 8);
      if (o_dispatch_valid !== 1'b1) begin err_total++; report_and_stop; end
      `CHK(o_dispatch_route, rt)
      `CHK(o_byte_lane_enables, be)
      `CHK(o_dispatch_write, wr)
   endtask

   // Snoop the oldest entry, strobe the response, judge the status
   task resp(input h, input [2:0] s);
      int i;
      i = 0;
      host.sq.push_back(h);
      do begin @(negedge i_ref_clk); i++; end while (o_resp_valid !== 1'b1 && i < 8);
      if (o_resp_valid !== 1'b1) begin err_total++; report_and_stop; end
      `CHK(st, s)
   endtask

   task txn(input [4:0] c1, c2, input [7:0] be, input d, c, l, h, input [2:0] rt, s);
      req(c1, c2, be, d, c, l);
      wait_disp(rt, c1 == 5'h09 ? 8'h00 : be,
         c1 == 5'h05 || c1 == 5'h07 || c1 == 5'h11 || (c1 == 5'h09 && c2 == 5'h00));
      resp(h, s);
   endtask

   // ----------------------------------------
   // Scenarios
   // ----------------------------------------
   task t_decode;
      txn(5'h06, 5'h02, 8'hff, 1, 0, 0, 0, 1, 7);
      txn(5'h02, 5'h01, 8'hff, 0, 0, 0, 0, 2, 7);
      txn(5'h04, 5'h00, 8'h0f, 1, 0, 0, 0, 1, 7);
      txn(5'h05, 5'h02, 8'hff, 0, 0, 0, 0, 1, 5);
      txn(5'h07, 5'h00, 8'h01, 0, 0, 0, 0, 2, 5);
      txn(5'h07, 5'h01, 8'hff, 1, 0, 0, 0, 1, 5);
      txn(5'h10, 5'h00, 8'h01, 0, 0, 0, 0, 2, 7);
      txn(5'h11, 5'h00, 8'h01, 0, 0, 0, 0, 2, 5);
      txn(5'h10, 5'h00, 8'h01, 0, 1, 0, 0, 3, 7);
      txn(5'h11, 5'h00, 8'h01, 0, 1, 0, 0, 3, 5);
      txn(5'h08, 5'h00, 8'hff, 0, 0, 0, 0, 2, 7);
      txn(5'h08, 5'h01, 8'h03, 0, 0, 0, 0, 4, 5);
      txn(5'h00, 5'h05, 8'hff, 0, 0, 0, 0, 5, 5);
      txn(5'h09, 5'h00, 8'hff, 1, 0, 0, 0, 6, 5);
      txn(5'h01, 5'h00, 8'hff, 1, 0, 0, 0, 0, 5);
      txn(5'h08, 5'h02, 8'hff, 0, 0, 0, 0, 0, 5);
      txn(5'h06, 5'h03, 8'hff, 1, 0, 0, 0, 0, 5);
      txn(5'h06, 5'h08, 8'hff, 1, 0, 0, 0, 0, 5);
      txn(5'h06, 5'h00, 8'h00, 1, 0, 0, 0, 1, 5);
      $display("test decode done");
   endtask

   task t_response;
      i_hub_busy = 1;
      txn(5'h06, 5'h00, 8'hff, 0, 0, 0, 0, 2, 1);
      txn(5'h07, 5'h00, 8'hff, 0, 0, 0, 0, 2, 1);
      i_hub_busy = 0;
      i_dram_busy = 1;
      txn(5'h06, 5'h00, 8'hff, 1, 0, 1, 0, 1, 1);
      txn(5'h05, 5'h00, 8'hff, 1, 0, 0, 0, 1, 5);
      txn(5'h06, 5'h00, 8'hff, 1, 0, 0, 0, 1, 7);
      i_dram_busy = 0;
      i_defer_enable = 1;
      txn(5'h06, 5'h00, 8'hff, 0, 0, 0, 0, 2, 2);
      txn(5'h11, 5'h00, 8'h01, 0, 0, 0, 0, 2, 2);
      txn(5'h07, 5'h00, 8'hff, 0, 0, 0, 0, 2, 5);
      txn(5'h06, 5'h00, 8'hff, 1, 0, 0, 0, 1, 7);
      i_defer_enable = 0;
      txn(5'h06, 5'h00, 8'hff, 1, 0, 0, 1, 1, 6);
      $display("test response done");
   endtask

   // Five back to back requests: the fifth meets a full queue and is lost
   task t_order;
      int n;
      n = 0;
      req(5'h06, 5'h00, 8'hff, 1, 0, 0);
      req(5'h07, 5'h00, 8'hff, 1, 0, 0);
      req(5'h10, 5'h00, 8'h01, 0, 0, 0);
      req(5'h06, 5'h01, 8'hff, 1, 0, 0);
      req(5'h06, 5'h00, 8'hff, 1, 0, 0);
      repeat (9) begin @(negedge i_ref_clk); n += (o_dispatch_valid === 1'b1); end
      `CHK(n, 4)
      `CHK(o_ioq_full, 1'b1)
      resp(0, 3'h7);
      resp(0, 3'h5);
      resp(1, 3'h6);
      resp(0, 3'h7);
      `CHK(o_ioq_full, 1'b0)
      $display("test order done");
   endtask

   initial begin
      repeat (10) @(negedge i_ref_clk);
      i_sys_rst = 0;
      t_decode;
      t_response;
      t_order;
      report_and_stop;
   end
endmodule
